//--- rtl/dx_dram.sv
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module dx_dram (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_ce,
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [dx_pkg::PADDR_W-1:0]    i_paddr,
  input  wire logic [dx_pkg::PDATA_W-1:0]    i_pwdata,
  output logic      [dx_pkg::PDATA_W-1:0]    o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  input  wire logic                          i_ck,
  input  wire logic                          i_cke,
  input  wire dx_pkg::dx_cmd_type            i_cmd,
  input  wire logic [dx_pkg::ADDR_W-1:0]     i_addr,
  input  wire logic [dx_pkg::BANK_W-1:0]     i_ba,
  input  wire logic                          i_odt,
  input  wire logic [dx_pkg::DM_W-1:0]       i_dm,
  input  wire logic [dx_pkg::DQ_W-1:0]       i_dq,
  output logic      [dx_pkg::DQ_W-1:0]       o_dq,
  output logic                               o_dq_oe,
  output logic                               o_dqs,
  output logic                               o_dqs_oe,
  output logic                               o_term_en
);
  logic                                ce_m_r;
  logic                                ce_s_r;
  logic                                wp_m_r;
  logic                                wp_s_r;
  logic                                ctrl_wp_r;
  dx_pkg::dx_cmd_type                  cmd_q;
  logic [dx_pkg::ADDR_W-1:0]           addr_q;
  logic [dx_pkg::BANK_W-1:0]           ba_q;
  logic                                cke_q;
  logic                                cke_prev_r;
  logic                                odt_q;
  logic [dx_pkg::DM_W-1:0]             dm_q;
  logic [dx_pkg::DQ_W-1:0]             dq_q;
  dx_pkg::dx_pstate_type               pstate_r;
  logic [dx_pkg::NBANK-1:0]            open_r;
  logic [dx_pkg::NBANK-1:0][dx_pkg::ADDR_W-1:0] row_r;
  logic [dx_pkg::MR_N-1:0][dx_pkg::ADDR_W-1:0]  mr_r;
  logic [dx_pkg::LEFT_W-1:0]           burst_left_r;
  logic [dx_pkg::BEAT_W-1:0]           beat_r;
  logic                                burst_wr_r;
  logic                                burst_ap_r;
  logic                                burst_bc4_r;
  logic [dx_pkg::BANK_W-1:0]           burst_bank_r;
  logic [dx_pkg::COL_W-1:0]            burst_col_r;
  logic                                rd_vld_r;
  logic                                dqs_r;
  logic                                dqs_oe_r;
  logic                                term_r;
  logic                                cmd_ok;
  logic                                is_act;
  logic                                is_pre;
  logic                                is_mrs;
  logic                                is_rd;
  logic                                is_wr;
  logic                                burst_act;
  logic                                start_burst;
  logic [dx_pkg::LEFT_W-1:0]           blen;
  logic                                rtt_on;
  logic                                mem_we;
  logic [dx_pkg::MEM_AW-1:0]           mem_addr;
  logic [dx_pkg::DQ_W-1:0]             mem_rdata;
  dx_pkg::dx_stat_type                 stat_ck;
  dx_pkg::dx_stat_type                 stat_clk;
  logic [dx_pkg::PDATA_W-1:0]          rd_val;

  function automatic logic [dx_pkg::MEM_AW-1:0] mem_index(
    input logic [dx_pkg::BANK_W-1:0] bank,
    input logic [dx_pkg::ADDR_W-1:0] row,
    input logic [dx_pkg::COL_W-1:0]  col,
    input logic [dx_pkg::BEAT_W-1:0] beat,
    input logic                      bc4
  );
    logic [dx_pkg::COL_W-1:0] c;
    c = col;
    if (bc4)
      c[1:0] = col[1:0] + beat[1:0];
    else
      c[2:0] = col[2:0] + beat;
    return {bank, row[dx_pkg::MEM_ROW_W-1:0], c[dx_pkg::MEM_COL_W-1:0]};
  endfunction : mem_index

  function automatic logic mr_hit(input logic [dx_pkg::PADDR_W-1:0] a);
    return (a >= dx_pkg::REG_MR0) && (a <= dx_pkg::REG_MR3) && (a[1:0] == 2'h0);
  endfunction : mr_hit

  function automatic logic [dx_pkg::MR_SEL_W-1:0] mr_sel(
    input logic [dx_pkg::PADDR_W-1:0] a
  );
    logic [dx_pkg::PADDR_W-1:0] d;
    d = a - dx_pkg::REG_MR0;
    return d[dx_pkg::MR_SEL_LSB +: dx_pkg::MR_SEL_W];
  endfunction : mr_sel

  function automatic logic reg_ok(input logic [dx_pkg::PADDR_W-1:0] a);
    return (a == dx_pkg::REG_CTRL) || (a == dx_pkg::REG_STAT) || mr_hit(a);
  endfunction : reg_ok

  // clock enable and write protect reach the link domain through two flops
  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      ce_m_r <= 1'b0;
      ce_s_r <= 1'b0;
      wp_m_r <= 1'b0;
      wp_s_r <= 1'b0;
    end
    else
    begin
      ce_m_r <= i_ce;
      ce_s_r <= ce_m_r;
      wp_m_r <= ctrl_wp_r;
      wp_s_r <= wp_m_r;
    end
  end

  // pin registers on the rising link clock
  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      cmd_q  <= dx_pkg::CMD_DES;
      addr_q <= '0;
      ba_q   <= '0;
      cke_q  <= 1'b0;
      odt_q  <= 1'b0;
      dm_q   <= '0;
      dq_q   <= '0;
    end
    else if (ce_s_r)
    begin
      cmd_q  <= i_cmd;
      addr_q <= i_addr;
      ba_q   <= i_ba;
      cke_q  <= i_cke;
      odt_q  <= i_odt;
      dm_q   <= i_dm;
      dq_q   <= i_dq;
    end
  end

  assign cmd_ok = ce_s_r && cke_q && (pstate_r == dx_pkg::PS_ON) && !cmd_q.cs_n;
  assign is_act = cmd_ok && (cmd_q == dx_pkg::CMD_ACT);
  assign is_pre = cmd_ok && (cmd_q == dx_pkg::CMD_PRE);
  assign is_mrs = cmd_ok && (cmd_q == dx_pkg::CMD_MRS);
  assign is_rd  = cmd_ok && (cmd_q == dx_pkg::CMD_RD);
  assign is_wr  = cmd_ok && (cmd_q == dx_pkg::CMD_WR);

  assign burst_act   = (burst_left_r != '0);
  assign start_burst = (is_rd || is_wr) && !burst_act;

  // chop length from mode register 0, per command when on-the-fly
  always_comb
  begin
    unique case (mr_r[0][dx_pkg::MR0_BL_LSB +: 2])
      dx_pkg::BL_OTF:  blen = addr_q[dx_pkg::A_BC] ? dx_pkg::BEATS8 : dx_pkg::BEATS4;
      dx_pkg::BL_FIX4: blen = dx_pkg::BEATS4;
      default:         blen = dx_pkg::BEATS8;
    endcase
  end

  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      burst_left_r <= '0;
      beat_r       <= '0;
      burst_wr_r   <= 1'b0;
      burst_ap_r   <= 1'b0;
      burst_bc4_r  <= 1'b0;
      burst_bank_r <= '0;
      burst_col_r  <= '0;
    end
    else if (ce_s_r)
    begin
      if (start_burst)
      begin
        burst_left_r <= blen;
        beat_r       <= '0;
        burst_wr_r   <= is_wr;
        burst_ap_r   <= addr_q[dx_pkg::A_AP];
        burst_bc4_r  <= (blen == dx_pkg::BEATS4);
        burst_bank_r <= ba_q;
        burst_col_r  <= addr_q[dx_pkg::COL_W-1:0];
      end
      else if (burst_act)
      begin
        burst_left_r <= burst_left_r - 1'b1;
        beat_r       <= beat_r + 1'b1;
      end
    end
  end

  // open rows per bank
  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      open_r <= '0;
      row_r  <= '0;
    end
    else if (ce_s_r)
    begin
      if (burst_act && (burst_left_r == 4'h1) && burst_ap_r)
        open_r[burst_bank_r] <= 1'b0;
      if (is_act)
      begin
        open_r[ba_q] <= 1'b1;
        row_r[ba_q]  <= addr_q;
      end
      if (is_pre)
      begin
        if (addr_q[dx_pkg::A_AP])
          open_r <= '0;
        else
          open_r[ba_q] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
      mr_r <= '0;
    else if (ce_s_r && is_mrs)
      mr_r[ba_q[dx_pkg::MR_SEL_W-1:0]] <= addr_q;
  end

  // power states driven by registered clock enable
  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      pstate_r   <= dx_pkg::PS_ON;
      cke_prev_r <= 1'b0;
    end
    else if (ce_s_r)
    begin
      cke_prev_r <= cke_q;
      unique case (pstate_r)
        dx_pkg::PS_ON:
        begin
          if (cke_prev_r && !cke_q)
          begin
            if (cmd_q == dx_pkg::CMD_REF)
              pstate_r <= dx_pkg::PS_SREF;
            else if (open_r == '0)
              pstate_r <= dx_pkg::PS_PDN_PRE;
            else
              pstate_r <= dx_pkg::PS_PDN_ACT;
          end
        end
        dx_pkg::PS_PDN_PRE, dx_pkg::PS_PDN_ACT:
        begin
          if (cke_q)
            pstate_r <= dx_pkg::PS_ON;
        end
        dx_pkg::PS_SREF:
        begin
          if (cke_q)
            pstate_r <= dx_pkg::PS_ON;
        end
      endcase
    end
  end

  assign rtt_on = mr_r[1][dx_pkg::MR1_RTT_A] || mr_r[1][dx_pkg::MR1_RTT_B] ||
                  mr_r[1][dx_pkg::MR1_RTT_C];

  // termination covers the data group only
  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
      term_r <= 1'b0;
    else if (ce_s_r)
      term_r <= odt_q && rtt_on && (pstate_r != dx_pkg::PS_SREF);
  end

  assign o_term_en = term_r;

  assign mem_addr = mem_index(burst_bank_r, row_r[burst_bank_r], burst_col_r, beat_r,
                              burst_bc4_r);
  assign mem_we   = burst_act && burst_wr_r && !wp_s_r;

  dx_mem u_mem (
    .i_clk   (i_ck),
    .i_reset (i_reset),
    .i_ce    (ce_s_r),
    .i_we    (mem_we),
    .i_be    (~dm_q),
    .i_addr  (mem_addr),
    .i_wdata (dq_q),
    .o_rdata (mem_rdata)
  );

  // read beats and strobe leave on the same link clock edge
  always_ff @(posedge i_ck or posedge i_reset)
  begin
    if (i_reset)
    begin
      rd_vld_r <= 1'b0;
      dqs_r    <= 1'b0;
      dqs_oe_r <= 1'b0;
    end
    else if (ce_s_r)
    begin
      rd_vld_r <= burst_act && !burst_wr_r;
      dqs_oe_r <= burst_act && !burst_wr_r;
      dqs_r    <= (burst_act && !burst_wr_r) ? ~dqs_r : 1'b0;
    end
  end

  assign o_dq     = mem_rdata;
  assign o_dq_oe  = rd_vld_r;
  assign o_dqs    = dqs_r;
  assign o_dqs_oe = dqs_oe_r;

  assign stat_ck.mr     = mr_r;
  assign stat_ck.open   = open_r;
  assign stat_ck.pstate = pstate_r;

  dx_xfer #(
    .W ($bits(dx_pkg::dx_stat_type))
  ) u_xfer (
    .i_src_clk (i_ck),
    .i_dst_clk (i_clk),
    .i_reset   (i_reset),
    .i_data    (stat_ck),
    .o_data    (stat_clk)
  );

  // register slave, zero wait states while enabled
  always_comb
  begin
    rd_val = '0;
    if (i_paddr == dx_pkg::REG_CTRL)
      rd_val[dx_pkg::CTRL_WP] = ctrl_wp_r;
    else if (i_paddr == dx_pkg::REG_STAT)
    begin
      rd_val[dx_pkg::STAT_PS_LSB +: 2]              = stat_clk.pstate;
      rd_val[dx_pkg::STAT_OPEN_LSB +: dx_pkg::NBANK] = stat_clk.open;
    end
    else if (mr_hit(i_paddr))
      rd_val[dx_pkg::ADDR_W-1:0] = stat_clk.mr[mr_sel(i_paddr)];
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_prdata <= '0;
    else if (i_ce && i_psel && !i_penable && !i_pwrite)
      o_prdata <= rd_val;
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      ctrl_wp_r <= 1'b0;
    else if (i_ce && i_psel && i_penable && i_pwrite && (i_paddr == dx_pkg::REG_CTRL))
      ctrl_wp_r <= i_pwdata[dx_pkg::CTRL_WP];
  end

  assign o_pready  = i_ce;
  assign o_pslverr = i_psel && i_penable && !reg_ok(i_paddr);

  property p_act_open;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && is_act) |=> (open_r[$past(ba_q)] && (row_r[$past(ba_q)] == $past(addr_q)));
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate did not open bank");

  property p_pre_all;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && is_pre && addr_q[dx_pkg::A_AP]) |=> (open_r == '0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_pre_one;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && is_pre && !addr_q[dx_pkg::A_AP]) |=> !open_r[$past(ba_q)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("precharge left bank open");

  property p_mrs;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && is_mrs) |=> (mr_r[$past(ba_q[1:0])] == $past(addr_q));
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode register not loaded");

  property p_cs_ignore;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && cmd_q.cs_n && !burst_act) |=> ($stable(open_r) && $stable(mr_r));
  endproperty
  a_cs_ignore: assert property (p_cs_ignore) else $error("deselected command acted");

  property p_chop;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && start_burst && (mr_r[0][1:0] == dx_pkg::BL_OTF) && !addr_q[dx_pkg::A_BC])
      |=> (burst_left_r == dx_pkg::BEATS4) ##1
          (!$past(ce_s_r) || (burst_left_r == (dx_pkg::BEATS4 - 4'h1)));
  endproperty
  a_chop: assert property (p_chop) else $error("chopped burst length wrong");

  property p_term;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && odt_q && rtt_on && (pstate_r != dx_pkg::PS_SREF)) |=> o_term_en;
  endproperty
  a_term: assert property (p_term) else $error("termination not applied");

  property p_term_off;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && !rtt_on) |=> !o_term_en;
  endproperty
  a_term_off: assert property (p_term_off) else $error("termination despite disable");

  property p_pd_entry;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && (pstate_r == dx_pkg::PS_ON) && cke_prev_r && !cke_q &&
     (cmd_q != dx_pkg::CMD_REF) && (open_r == '0)) |=> (pstate_r == dx_pkg::PS_PDN_PRE);
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("no precharge power-down");

  property p_pd_quiet;
    @(posedge i_ck) disable iff (i_reset)
    (ce_s_r && (pstate_r != dx_pkg::PS_ON) && !burst_act)
      |=> ($stable(open_r) && $stable(mr_r));
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("command taken in power-down");

  property p_dqs;
    @(posedge i_ck) disable iff (i_reset)
    ($past(ce_s_r) && o_dqs_oe && $past(o_dqs_oe)) |-> (o_dq_oe && (o_dqs != $past(o_dqs)));
  endproperty
  a_dqs: assert property (p_dqs) else $error("strobe not toggling with data");
endmodule : dx_dram

//--- rtl/dx_mem.sv
`timescale 1ns/1ps
module dx_mem (
  input  wire logic                        i_clk,
  input  wire logic                        i_reset,
  input  wire logic                        i_ce,
  input  wire logic                        i_we,
  input  wire logic [dx_pkg::DM_W-1:0]     i_be,
  input  wire logic [dx_pkg::MEM_AW-1:0]   i_addr,
  input  wire logic [dx_pkg::DQ_W-1:0]     i_wdata,
  output logic      [dx_pkg::DQ_W-1:0]     o_rdata
);
  logic [dx_pkg::DQ_W-1:0] mem_r [0:(2**dx_pkg::MEM_AW)-1];

  // byte lanes with a low enable keep their old contents
  always_ff @(posedge i_clk)
  begin
    if (i_ce && i_we)
    begin
      for (int b = 0; b < dx_pkg::DM_W; b++)
      begin
        if (i_be[b])
        begin
          mem_r[i_addr][b*dx_pkg::BYTE_W +: dx_pkg::BYTE_W] <=
            i_wdata[b*dx_pkg::BYTE_W +: dx_pkg::BYTE_W];
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rdata <= '0;
    else if (i_ce)
      o_rdata <= mem_r[i_addr];
  end

  property p_keep;
    @(posedge i_clk) disable iff (i_reset)
    (i_ce && i_we && !i_be[0]) |=>
      (mem_r[$past(i_addr)][dx_pkg::BYTE_W-1:0] == $past(mem_r[i_addr][dx_pkg::BYTE_W-1:0]));
  endproperty
  a_keep: assert property (p_keep) else $error("masked byte overwritten");
endmodule : dx_mem

//--- rtl/dx_pkg.sv
package dx_pkg;
  localparam int ADDR_W   = 16;
  localparam int BANK_W   = 3;
  localparam int NBANK    = 8;
  localparam int DQ_W     = 16;
  localparam int BYTE_W   = 8;
  localparam int DM_W     = 2;
  localparam int MR_N     = 4;
  localparam int MR_SEL_W = 2;
  localparam int COL_W    = 10;
  localparam int A_AP     = 10;
  localparam int A_BC     = 12;
  localparam int BEAT_W   = 3;
  localparam int LEFT_W   = 4;
  localparam int MEM_ROW_W = 2;
  localparam int MEM_COL_W = 5;
  localparam int MEM_AW   = BANK_W + MEM_ROW_W + MEM_COL_W;

  localparam logic [LEFT_W-1:0] BEATS8 = 4'h8;
  localparam logic [LEFT_W-1:0] BEATS4 = 4'h4;

  localparam int MR0_BL_LSB = 0;
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF  = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam int MR1_RTT_A = 2;
  localparam int MR1_RTT_B = 6;
  localparam int MR1_RTT_C = 9;

  // command code is {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DES = 4'hF;

  localparam int PADDR_W = 8;
  localparam int PDATA_W = 32;
  localparam logic [PADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] REG_STAT = 8'h04;
  localparam logic [PADDR_W-1:0] REG_MR0  = 8'h08;
  localparam logic [PADDR_W-1:0] REG_MR3  = 8'h14;
  localparam int CTRL_WP       = 0;
  localparam int STAT_PS_LSB   = 0;
  localparam int STAT_OPEN_LSB = 8;
  localparam int MR_SEL_LSB    = 2;

  typedef enum logic [1:0] {
    PS_ON      = 2'b00,
    PS_PDN_PRE = 2'b01,
    PS_PDN_ACT = 2'b10,
    PS_SREF    = 2'b11
  } dx_pstate_type;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dx_cmd_type;

  typedef struct packed {
    logic [MR_N-1:0][ADDR_W-1:0] mr;
    logic [NBANK-1:0]            open;
    dx_pstate_type               pstate;
  } dx_stat_type;
endpackage : dx_pkg

//--- rtl/dx_xfer.sv
`timescale 1ns/1ps
module dx_xfer #(
  parameter int W = 8
) (
  input  wire logic          i_src_clk,
  input  wire logic          i_dst_clk,
  input  wire logic          i_reset,
  input  wire logic [W-1:0]  i_data,
  output logic      [W-1:0]  o_data
);
  logic         req_r;
  logic         ack_r;
  logic         ack_m_r;
  logic         ack_s_r;
  logic         req_m_r;
  logic         req_s_r;
  logic [W-1:0] hold_r;

  // toggle handshake: hold only changes once the far side has taken it
  always_ff @(posedge i_src_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
    end
    else
    begin
      ack_m_r <= ack_r;
      ack_s_r <= ack_m_r;
    end
  end

  always_ff @(posedge i_src_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      req_r  <= 1'b0;
      hold_r <= '0;
    end
    else if (req_r == ack_s_r)
    begin
      hold_r <= i_data;
      req_r  <= ~req_r;
    end
  end

  always_ff @(posedge i_dst_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      ack_r   <= 1'b0;
      o_data  <= '0;
    end
    else
    begin
      req_m_r <= req_r;
      req_s_r <= req_m_r;
      ack_r   <= req_s_r;
      if (req_s_r != ack_r)
        o_data <= hold_r;
    end
  end
endmodule : dx_xfer

//--- tb/ddr3_x16_command_pin_interface_tb.sv
`timescale 1ns/1ps
module ddr3_x16_command_pin_interface_tb;
  logic               clk = 1'b0;
  logic               ck = 1'b0;
  logic               reset = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic               ce = 1'b1;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata, rd;
  logic               se, pready, pslverr, cke, odt, dq_oe, dqs, dqs_oe, term_en;
  dx_pkg::dx_cmd_type cmd;
  logic [15:0]        addr, dq_in, dq;
  logic [2:0]         ba;
  logic [1:0]         dm;
  logic [15:0]        mr_op [4] = '{16'h0001, 16'h0004, 16'h0018, 16'h0003};
  int                 error_cnt = 0;
  int                 total_checks = 0;
  always #12.5 clk = ~clk;
  always #40 ck = ~ck;
  dx_ctl ctl (.i_ck(ck), .o_cke(cke), .o_cmd(cmd), .o_addr(addr), .o_ba(ba), .o_odt(odt),
    .o_dm(dm), .o_dq(dq_in));
  dx_dram dut (.i_clk(clk), .i_reset(reset), .i_ce(ce), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ck(ck), .i_cke(cke), .i_cmd(cmd),
    .i_addr(addr), .i_ba(ba), .i_odt(odt), .i_dm(dm), .i_dq(dq_in), .o_dq(dq),
    .o_dq_oe(dq_oe), .o_dqs(dqs), .o_dqs_oe(dqs_oe), .o_term_en(term_en));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic stat(input logic [31:0] e);
    repeat (16) @(posedge ck);
    apb(1'b0, dx_pkg::REG_STAT);
    chk(rd, e);
  endtask : stat
  // beats of the masked write pair, read back from column 0
  task automatic burst(input int n);
    while (dq_oe !== 1'b1) @(negedge ck);
    for (int j = 0; j < n; j++)
    begin
      chk(dq, (j == 2) ? 16'hA502 : 16'h5A00 + 16'(j));
      chk(dqs, {31'h0, ~j[0]});
      @(negedge ck);
    end
    chk(dq_oe, 1'b0);
  endtask : burst
  initial
  begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge ck);
    chk(dq_oe, 1'b0);
    stat(32'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
      ctl.xfer(dx_pkg::CMD_MRS, 3'(i), mr_op[i]);
    repeat (8) @(posedge ck);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, dx_pkg::REG_MR0 + 8'(4 * i));
      chk(rd, {16'h0, mr_op[i]});
    end
    $display("mode load test done");
    ctl.xfer(dx_pkg::CMD_ACT, 3'h3, 16'h0001);
    stat(32'h0000_0800);
    ctl.xfer(dx_pkg::CMD_WR, 3'h3, 16'h1000, 8, 16'hA500);
    ctl.xfer(dx_pkg::CMD_WR, 3'h3, 16'h1000, 8, 16'h5A00, 2);
    ctl.xfer(4'hC, 3'h3, 16'h1000, 8, 16'h3300);
    ctl.xfer(dx_pkg::CMD_RD, 3'h3, 16'h1000);
    burst(8);
    ctl.xfer(dx_pkg::CMD_RD, 3'h3, 16'h0000);
    burst(4);
    apb(1'b1, dx_pkg::REG_CTRL, 32'h1);
    apb(1'b0, dx_pkg::REG_CTRL);
    chk(rd, 32'h1);
    ctl.xfer(dx_pkg::CMD_WR, 3'h3, 16'h1000, 8, 16'h7700);
    repeat (12) @(posedge ck);
    apb(1'b1, dx_pkg::REG_CTRL, 32'h0);
    ctl.xfer(dx_pkg::CMD_RD, 3'h3, 16'h1000);
    burst(8);
    $display("burst test done");
    ctl.xfer(dx_pkg::CMD_ACT, 3'h5, 16'h0002);
    ctl.xfer(dx_pkg::CMD_PRE, 3'h3, 16'h0000);
    stat(32'h0000_2000);
    ctl.xfer(dx_pkg::CMD_WR, 3'h5, 16'h0400, 4, 16'h6600);
    stat(32'h0);
    ctl.xfer(dx_pkg::CMD_ACT, 3'h5, 16'h0002);
    ctl.xfer(dx_pkg::CMD_ACT, 3'h2, 16'h0001);
    stat(32'h0000_2400);
    ctl.xfer(dx_pkg::CMD_PRE, 3'h0, 16'h0400);
    stat(32'h0);
    $display("precharge test done");
    ctl.xfer(dx_pkg::CMD_ACT, 3'h1, 16'h0000, 0, 16'h0000, -1, 1'b0, 1'b1);
    stat(32'h1);
    chk(term_en, 1'b1);
    ctl.xfer(dx_pkg::CMD_ACT, 3'h1, 16'h0000, 0, 16'h0000, -1, 1'b1, 1'b1);
    stat(32'h0);
    ctl.xfer(dx_pkg::CMD_REF, 3'h0, 16'h0000, 0, 16'h0000, -1, 1'b0, 1'b1);
    stat(32'h3);
    chk(term_en, 1'b0);
    ctl.xfer(dx_pkg::CMD_NOP, 3'h0, 16'h0000, 0, 16'h0000, -1, 1'b1, 1'b0);
    stat(32'h0);
    chk(term_en, 1'b0);
    ctl.xfer(dx_pkg::CMD_MRS, 3'h1, 16'h0000, 0, 16'h0000, -1, 1'b1, 1'b1);
    stat(32'h0);
    chk(term_en, 1'b0);
    $display("power test done");
    apb(1'b0, 8'h40);
    chk(se, 1'b1);
    chk(rd, 32'h0);
    ce <= 1'b0;
    @(posedge clk);
    chk(pready, 1'b0);
    ce <= 1'b1;
    $display("bus test done");
    wrap_up();
  end
endmodule : ddr3_x16_command_pin_interface_tb

//--- tb/dx_ctl.sv
`timescale 1ns/1ps
module dx_ctl (
  input  wire logic                 i_ck,
  output logic                      o_cke,
  output dx_pkg::dx_cmd_type        o_cmd,
  output logic [dx_pkg::ADDR_W-1:0] o_addr,
  output logic [dx_pkg::BANK_W-1:0] o_ba,
  output logic                      o_odt,
  output logic [dx_pkg::DM_W-1:0]   o_dm,
  output logic [dx_pkg::DQ_W-1:0]   o_dq
);
  initial
  begin
    o_cke  = 1'b1;
    o_cmd  = dx_pkg::CMD_NOP;
    o_addr = 16'h0000;
    o_ba   = 3'h0;
    o_odt  = 1'b0;
    o_dm   = 2'h0;
    o_dq   = 16'h0000;
  end
  // one command, then n write beats from base, beat mb masked
  task automatic xfer(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a,
                      input int n = 0, input logic [15:0] base = 16'h0000,
                      input int mb = -1, input logic k = 1'b1, input logic t = 1'b0);
    @(posedge i_ck);
    o_cmd  <= c;
    o_ba   <= b;
    o_addr <= a;
    o_cke  <= k;
    o_odt  <= t;
    @(posedge i_ck);
    o_cmd  <= dx_pkg::CMD_NOP;
    o_addr <= ~a;
    o_ba   <= ~b;
    for (int j = 0; j < n; j++)
    begin
      o_dq <= base + 16'(j);
      o_dm <= (j == mb) ? 2'h3 : 2'h0;
      @(posedge i_ck);
    end
    o_dq <= ~o_dq;
    o_dm <= 2'h0;
  endtask : xfer
endmodule : dx_ctl
